// [shared/sbs_cfg.svh]
// Constants for the signed binary subtractor block.
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
`define SBS_OP_SUB16 12'h410
`define SBS_OP_SUB32 12'h411
`define SBS_ADDR_CTRL 12'h000
`define SBS_ADDR_MIN 12'h004
`define SBS_ADDR_SUB 12'h008
`define SBS_ADDR_RES 12'h00c
`define SBS_ADDR_FLAGS 12'h010
`define SBS_CTRL_OPC_LSB 0
`define SBS_CTRL_OPC_MSB 11
`define SBS_CTRL_GO_BIT 16
`define SBS_FLAG_ER 0
`define SBS_FLAG_EQ 1
`define SBS_FLAG_CY 2
`define SBS_FLAG_OF 3
`define SBS_FLAG_UF 4
`define SBS_FLAG_N 5
`define SBS_FLAG_BADOP 8
`define SBS_FLAG_DONE 9
`define SBS_RESET_WORD 32'h0000_0000
`define SBS_RESET_HALF 16'h0000
`define SBS_RESET_FLAGS 6'h00
`endif

// [shared/sbs_pkg.sv]
// Types shared by the signed binary subtractor modules.
package sbs_pkg;
  typedef enum logic [1:0] {
    SBS_W16 = 2'b01,
    SBS_W32 = 2'b10
  } sbs_width_e;
  typedef struct packed {
    logic negative_flag;
    logic underflow_flag;
    logic overflow_flag;
    logic carry_borrow_flag;
    logic equals_flag;
    logic error_flag;
  } sbs_flags_s;
endpackage

// [shared/sbs_alu_if.sv]
// Operand and result bundle between the register shell and the subtract core.
`timescale 1ns/1ps
interface sbs_alu_if;
  import sbs_pkg::*;
  logic [31:0] minuend_operand;
  logic [31:0] subtrahend_operand;
  sbs_width_e width;
  logic [31:0] difference;
  sbs_flags_s flags;
  modport shell (output minuend_operand, output subtrahend_operand, output width,
    input difference, input flags);
  modport core (input minuend_operand, input subtrahend_operand, input width,
    output difference, output flags);
endinterface

// [logic/sbs_core.sv]
// Combinational signed subtract core producing difference and condition flags.
`timescale 1ns/1ps
module sbs_core
  import sbs_pkg::*;
(
  // Operand and result bundle.
  sbs_alu_if.core alu
);
  logic [32:0] wide;
  logic [16:0] narrow;
  logic sa;
  logic sb;
  logic sr;
  logic cy;
  logic [31:0] diff;
  sbs_flags_s fl;

  always_comb begin
    // Borrow is the inverted carry of a + ~b + 1.
    wide = {1'b0, alu.minuend_operand} + {1'b0, ~alu.subtrahend_operand} + 33'h0_0000_0001;
    narrow = {1'b0, alu.minuend_operand[15:0]} + {1'b0, ~alu.subtrahend_operand[15:0]}
      + 17'h0_0001;
    if (alu.width == SBS_W32) begin
      diff = wide[31:0];
      cy = ~wide[32];
      sa = alu.minuend_operand[31];
      sb = alu.subtrahend_operand[31];
      sr = wide[31];
    end else begin
      diff = {16'h0000, narrow[15:0]};
      cy = ~narrow[16];
      sa = alu.minuend_operand[15];
      sb = alu.subtrahend_operand[15];
      sr = narrow[15];
    end
    fl.error_flag = 1'b0;
    fl.equals_flag = (diff == 32'h0000_0000);
    fl.carry_borrow_flag = cy;
    fl.overflow_flag = ~sa & sb & sr;
    fl.underflow_flag = sa & ~sb & ~sr;
    fl.negative_flag = sr;
  end

  assign alu.difference = diff;
  assign alu.flags = fl;
endmodule // sbs_core

// [logic/sbs_top.sv]
// APB register shell of the signed binary subtractor.
//
// Contract
// - 16-bit form writes minuend minus subtrahend
// - 32-bit form subtracts two-word operands
// - Negative results stored as two's complement
// - Equals flag set on zero difference
// - Carry flag set on borrow out
// - 16-bit overflow: positive minus negative wraps
// - 32-bit overflow: positive minus negative wraps
// - 32-bit underflow: negative minus positive wraps
// - Negative flag copies result top bit
// - Operands signed, one or two words
// - Opcode 410 selects 16, 411 selects 32
`timescale 1ns/1ps
`include "sbs_cfg.svh"
module sbs_top
  import sbs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  sbs_alu_if alu ();

  // Register slots of the address map, one select bit each.
  localparam int SLOT_CTRL = 0;
  localparam int SLOT_MIN = 1;
  localparam int SLOT_SUB = 2;
  localparam int SLOT_RES = 3;
  localparam int SLOT_FLAGS = 4;
  localparam int NSLOTS = 5;
  // The double-word result is kept as two consecutive 16-bit words.
  localparam int NWORDS = 2;

  logic [31:0] min_reg;
  logic [31:0] sub_reg;
  logic [11:0] opc_reg;
  sbs_flags_s flags_reg;
  logic badop_reg;
  logic done_reg;
  wire [NWORDS*16-1:0] res_word;
  logic [NSLOTS-1:0] slot_hit;
  logic [NSLOTS-1:0] wr_stb;
  logic [11:0] wr_opcode;
  logic [1:0] wr_width;
  logic [31:0] flag_word;
  logic [31:0] prdata_next;
  logic wr_en;
  logic rd_setup;
  logic go;
  logic op_ok;
  logic exec;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  function automatic logic [1:0] decode_op(input logic [11:0] opc);
    if (opc == `SBS_OP_SUB32) begin
      decode_op = SBS_W32;
    end else if (opc == `SBS_OP_SUB16) begin
      decode_op = SBS_W16;
    end else begin
      decode_op = 2'b00;
    end
  endfunction

  // One-hot slot select; all zero for an unmapped address.
  function automatic logic [NSLOTS-1:0] slot_of(input logic [11:0] a);
    slot_of = '0;
    case (a)
      `SBS_ADDR_CTRL: slot_of[SLOT_CTRL] = 1'b1;
      `SBS_ADDR_MIN: slot_of[SLOT_MIN] = 1'b1;
      `SBS_ADDR_SUB: slot_of[SLOT_SUB] = 1'b1;
      `SBS_ADDR_RES: slot_of[SLOT_RES] = 1'b1;
      `SBS_ADDR_FLAGS: slot_of[SLOT_FLAGS] = 1'b1;
      default: slot_of = '0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus side: strobes, ready and slave error.

  assign slot_hit = slot_of(paddr);
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(|slot_hit);
  assign wr_stb = {NSLOTS{wr_en}} & slot_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Control word: opcode field and go bit of a control write.

  assign wr_opcode = pwdata[`SBS_CTRL_OPC_MSB:`SBS_CTRL_OPC_LSB];
  assign wr_width = decode_op(wr_opcode);
  assign op_ok = (wr_width != 2'b00);
  assign go = wr_stb[SLOT_CTRL] & pwdata[`SBS_CTRL_GO_BIT];
  assign exec = go & op_ok;

  // The width comes from the opcode being written, so the subtract runs on
  // the very edge that takes the control write.
  assign alu.minuend_operand = min_reg;
  assign alu.subtrahend_operand = sub_reg;
  assign alu.width = sbs_width_e'(wr_width);

  sbs_core u_core (
    .alu(alu)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Operand registers, one bus word each for both forms.

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      min_reg <= `SBS_RESET_WORD;
    end else if (wr_stb[SLOT_MIN]) begin
      min_reg <= pwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sub_reg <= `SBS_RESET_WORD;
    end else if (wr_stb[SLOT_SUB]) begin
      sub_reg <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Execute: a control write with go set runs the selected subtract.
  // An unknown opcode is recorded but leaves the result and flags untouched.

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      opc_reg <= 12'h000;
    end else if (go) begin
      opc_reg <= wr_opcode;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      badop_reg <= 1'b0;
    end else if (go) begin
      badop_reg <= ~op_ok;
    end
  end

  for (genvar w = 0; w < NWORDS; w++) begin : g_res_word
    logic [15:0] word_reg;
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        word_reg <= `SBS_RESET_HALF;
      end else if (exec) begin
        word_reg <= alu.difference[16*w +: 16];
      end
    end
    assign res_word[16*w +: 16] = word_reg;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flags_reg <= `SBS_RESET_FLAGS;
    end else if (exec) begin
      flags_reg <= alu.flags;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      done_reg <= 1'b0;
    end else if (exec) begin
      done_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data is chosen in the setup cycle and stands through the access phase.

  always_comb begin
    flag_word = 32'h0000_0000;
    flag_word[`SBS_FLAG_ER] = flags_reg.error_flag;
    flag_word[`SBS_FLAG_EQ] = flags_reg.equals_flag;
    flag_word[`SBS_FLAG_CY] = flags_reg.carry_borrow_flag;
    flag_word[`SBS_FLAG_OF] = flags_reg.overflow_flag;
    flag_word[`SBS_FLAG_UF] = flags_reg.underflow_flag;
    flag_word[`SBS_FLAG_N] = flags_reg.negative_flag;
    flag_word[`SBS_FLAG_BADOP] = badop_reg;
    flag_word[`SBS_FLAG_DONE] = done_reg;
  end

  always_comb begin
    prdata_next = prdata;
    if (rd_setup) begin
      case (paddr)
        `SBS_ADDR_CTRL: prdata_next = {20'h0_0000, opc_reg};
        `SBS_ADDR_MIN: prdata_next = min_reg;
        `SBS_ADDR_SUB: prdata_next = sub_reg;
        `SBS_ADDR_RES: prdata_next = res_word;
        `SBS_ADDR_FLAGS: prdata_next = flag_word;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prdata <= `SBS_RESET_WORD;
    end else begin
      prdata <= prdata_next;
    end
  end
endmodule // sbs_top

// [tb/sbs_properties.sv]
// Checker of the subtractor register port.
`timescale 1ns/1ps
`include "sbs_cfg.svh"
module sbs_properties (
  // Watched ports.
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire a = psel && penable;
  wire f = a && !pwrite && paddr == `SBS_ADDR_FLAGS;
  chk_error_clear: assert property (f |-> !prdata[0]) else $error("error flag");
  chk_equal_flags: assert property (f && prdata[1] |-> !prdata[5] && !prdata[2])
    else $error("equals");
  chk_over_neg: assert property (f && prdata[3] |-> prdata[5]) else $error("overflow");
  chk_under_pos: assert property (f && prdata[4] |-> !prdata[5]) else $error("underflow");
  chk_over_under: assert property (f |-> !(prdata[3] && prdata[4])) else $error("both");
  chk_ready_high: assert property (a |-> pready) else $error("ready");
  chk_bad_addr: assert property (a && paddr > 12'h010 |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped");
  chk_good_addr: assert property (a && paddr <= 12'h010 && paddr[1:0] == 0 |-> !pslverr)
    else $error("mapped");
  cover property (f && prdata[3]);
  cover property (f && prdata[4]);
  cover property (f && prdata[1]);
endmodule // sbs_properties

// [tb/sbs_apb_master.sv]
// Sequencer model that issues register transfers to the subtractor.
`timescale 1ns/1ps
module sbs_apb_master (
  // Bus.
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] q;
  logic e;
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  task automatic io(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    pwdata <= ~d;
  endtask
endmodule // sbs_apb_master

// [tb/tb.sv]
// Self-checking bench for the signed binary subtractor.
`timescale 1ns/1ps
`include "sbs_cfg.svh"
module tb;
  logic mclk = 0;
  logic resetn = 0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  sbs_apb_master m (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sbs_top dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic sub(input logic w, input logic [31:0] a, input logic [31:0] b);
    logic [32:0] d;
    logic [31:0] r;
    logic sa, sb, sr, cy;
    logic [31:0] fx;
    d = w ? {1'b0, a} - {1'b0, b} : {17'h0, a[15:0]} - {17'h0, b[15:0]};
    r = w ? d[31:0] : {16'h0, d[15:0]};
    sa = w ? a[31] : a[15];
    sb = w ? b[31] : b[15];
    sr = w ? d[31] : d[15];
    cy = w ? d[32] : d[16];
    fx = {22'h0, 2'b10, 2'b00, sr, sa & !sb & !sr, !sa & sb & sr, cy, r == 0, 1'b0};
    m.io(1, `SBS_ADDR_MIN, a);
    m.io(1, `SBS_ADDR_SUB, b);
    m.io(1, `SBS_ADDR_CTRL, w ? 32'h10411 : 32'h10410);
    m.io(0, `SBS_ADDR_RES, 32'h0);
    cmp(m.q, r);
    m.io(0, `SBS_ADDR_FLAGS, 32'h0);
    cmp({22'h0, m.q[9:0]}, fx);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1;
    sub(0, 32'h5, 32'h3);
    sub(0, 32'h3, 32'h5);
    sub(0, 32'h7fff, 32'hffff);
    sub(0, 32'h8000, 32'h1);
    sub(0, 32'h1234, 32'h1234);
    sub(0, 32'habcd_0003, 32'h5a5a_0005);
    sub(1, 32'h20f55a10, 32'hb8a360e3);
    sub(1, 32'h7fffffff, 32'hffffffff);
    sub(1, 32'h80000000, 32'h1);
    sub(1, 32'h0, 32'h0);
    m.io(1, `SBS_ADDR_CTRL, 32'h0001_0412);
    m.io(0, `SBS_ADDR_FLAGS, 32'h0);
    cmp(m.q, 32'h0000_0302);
    m.io(0, `SBS_ADDR_RES, 32'h0);
    cmp(m.q, 32'h0000_0000);
    m.io(0, `SBS_ADDR_CTRL, 32'h0);
    cmp(m.q, 32'h0000_0412);
    m.io(0, 12'h020, 32'h0);
    cmp({31'h0, m.e}, 32'h1);
    conclude();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      conclude();
    end
  end
endmodule // tb
bind sbs_top sbs_properties chk (.mclk(mclk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
